// ===== logic/sprxtx_regs.sv
// Receive user-bit buffer configuration and transmitter control bank.
// Assumes receiver events arrive as one-cycle pulses on clk_i and that
// the transmitter clock mux and the serialiser sit outside this block.
// The user-bit memory sits outside as well; only its write port is here.
// Reserved mode and clock codes are stored as written; mode 11 acts as idle, clock 11 is passed on as is.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module sprxtx_regs
	import sprxtx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [sprxtx_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sprxtx_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [sprxtx_pkg::DATA_W-1:0] rdata_o,
	// Receiver side events
	input wire logic user_bit_valid_i,
	input wire logic user_bit_i,
	input wire logic user_chan_b_i,
	input wire logic preamble_z_i,
	input wire logic user_irq_evt_i,
	input wire logic dat_category_i,
	input wire logic start_id_bit_i,
	input wire logic professional_flag_i,
	input wire logic cs_block_done_i,
	input wire logic cs_head_changed_i,
	// Buffer write port
	output logic ubuf_we_o,
	output logic ubuf_sel_o,
	output logic ubuf_chan_b_o,
	output logic [9:0] ubuf_addr_o,
	output logic ubuf_data_o,
	output logic [1:0] user_format_o,
	// Transmitter controls
	input wire logic tx_subframe_i,
	output logic tx_run_o,
	output logic tx_validity_o,
	output logic [1:0] transmit_clock_select_o,
	output logic [2:0] transmit_ratio_o,
	output logic ratio_valid_o,
	output logic irq_o
);
	import sprxtx_pkg::*;

	// -----------------------------------------------------------------
	// Register bank
	// -----------------------------------------------------------------
	logic [7:0] rx_cfg_q;
	logic [7:0] tx_ctrl_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [7:0] rdata_q;
	logic user_evt;
	logic cs_evt;
	logic prev_start_q;
	logic [9:0] wptr_q;
	logic bank_q;
	logic seen_z_q;
	logic z_start;
	// Field views of the receive buffer configuration
	logic [1:0] user_buffer_mode;
	logic user_buffer_size;
	logic user_bit_split;
	logic cs_interrupt_mode;
	logic dat_interrupt_filter;
	logic [9:0] buf_last;
	// Registered buffer write port
	logic ubuf_we_q;
	logic ubuf_sel_q;
	logic ubuf_chan_q;
	logic [9:0] ubuf_addr_q;
	logic ubuf_data_q;
	logic tx_val_q;

	function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
		hit = (a == off);
	endfunction : hit

	// Modes 01 and 10 keep user bits; 00 drops them, 11 is reserved
	function automatic logic stores_bits(input logic [1:0] mode);
		stores_bits = (mode == MODE_PINGPONG) || (mode == MODE_FORMAT);
	endfunction : stores_bits

	// -----------------------------------------------------------------
	// Field decode
	// -----------------------------------------------------------------
	assign user_buffer_size = rx_cfg_q[RXB_SIZE_BIT];
	assign user_buffer_mode = rx_cfg_q[RXB_MODE_LSB +: 2];
	assign cs_interrupt_mode = rx_cfg_q[RXB_CSMODE_BIT];
	assign user_bit_split = rx_cfg_q[RXB_SPLIT_BIT];
	assign dat_interrupt_filter = rx_cfg_q[RXB_DATF_BIT];

	// R13: reserved bits dropped
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			rx_cfg_q <= RXB_RESET;
			tx_ctrl_q <= TX_RESET;
			irq_mask_q <= IRQ_W_RESET;
		end
		else if (ce_i && wr_i)
		begin
			if (hit(addr_i, RX_BUF_CFG_OFF))
				rx_cfg_q <= wdata_i & RXB_WMASK;
			if (hit(addr_i, TX_CTRL_OFF))
				tx_ctrl_q <= wdata_i & TX_WMASK;
			if (hit(addr_i, IRQ_MASK_OFF))
				irq_mask_q <= wdata_i[1:0];
		end
	end

	// Read data stands for one enabled cycle only, then falls back to zero
	// R13: reserved bits read zero
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			rdata_q <= 8'h00;
		else if (ce_i)
		begin
			rdata_q <= 8'h00;
			if (rd_i)
			begin
				case (addr_i)
					RX_BUF_CFG_OFF: rdata_q <= rx_cfg_q;
					TX_CTRL_OFF: rdata_q <= tx_ctrl_q;
					IRQ_STAT_OFF: rdata_q <= {6'h00, irq_stat_q};
					IRQ_MASK_OFF: rdata_q <= {6'h00, irq_mask_q};
					RX_STAT_OFF: rdata_q <= {6'h00, seen_z_q, bank_q};
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign rdata_o = rdata_q;

	// -----------------------------------------------------------------
	// Interrupt events
	// -----------------------------------------------------------------
	// Start bit of the last raw event, kept even when it is filtered
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			prev_start_q <= 1'b0;
		else if (ce_i && user_irq_evt_i)
			prev_start_q <= start_id_bit_i;
	end

	// Filter only touches consumer data of the DAT category
	// R1: DAT start-bit filter
	always_comb
	begin
		user_evt = user_irq_evt_i;
		if (dat_interrupt_filter && dat_category_i && !professional_flag_i
			&& user_buffer_mode == MODE_FORMAT)
			user_evt = user_irq_evt_i && (start_id_bit_i != prev_start_q);
	end

	// R3: every block in mode 0
	// R4: changed head in mode 1
	assign cs_evt = cs_block_done_i && (!cs_interrupt_mode || cs_head_changed_i);

	// Set wins over the read-clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			irq_stat_q <= IRQ_W_RESET;
		else if (ce_i)
		begin
			if (rd_i && hit(addr_i, IRQ_STAT_OFF))
				irq_stat_q <= {cs_evt, user_evt};
			else
				irq_stat_q <= irq_stat_q | {cs_evt, user_evt};
		end
	end
	// irq_stat bit 1 is the receive channel-status block flag
	assign irq_o = |(irq_stat_q & irq_mask_q);

	// -----------------------------------------------------------------
	// User-bit buffer addressing
	// -----------------------------------------------------------------
	// R8: 384 or 768 bits per buffer
	assign buf_last = user_buffer_size ? 10'(BUF_LARGE_BITS - 1)
		: 10'(BUF_SMALL_BITS - 1);

	// A Z opens a buffer when none is open or the last one just wrapped
	assign z_start = preamble_z_i && (!seen_z_q || wptr_q == 10'h000);

	// R5: mode 00 or 11 stores nothing
	// R6: ping-pong between buffers
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			wptr_q <= 10'h000;
			bank_q <= 1'b0;
			seen_z_q <= 1'b0;
		end
		else if (ce_i && user_bit_valid_i)
		begin
			if (!stores_bits(user_buffer_mode))
			begin
				// Idle rewinds so the next Z lands at 0
				seen_z_q <= 1'b0;
				wptr_q <= 10'h000;
			end
			// R8: buffer starts at preamble Z
			else if (z_start)
			begin
				seen_z_q <= 1'b1;
				wptr_q <= 10'h001;
			end
			else if (seen_z_q)
			begin
				if (wptr_q == buf_last)
				begin
					wptr_q <= 10'h000;
					if (user_buffer_mode == MODE_PINGPONG)
						bank_q <= ~bank_q;
				end
				else
					wptr_q <= wptr_q + 10'h001;
			end
		end
	end

	// R2: split or shared A/B storage
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			ubuf_we_q <= 1'b0;
			ubuf_sel_q <= 1'b0;
			ubuf_chan_q <= 1'b0;
			ubuf_addr_q <= 10'h000;
			ubuf_data_q <= 1'b0;
		end
		else if (ce_i)
		begin
			// Bits before the first Z have no place and are dropped
			ubuf_we_q <= user_bit_valid_i && stores_bits(user_buffer_mode)
				&& (seen_z_q || preamble_z_i);
			ubuf_sel_q <= bank_q;
			ubuf_chan_q <= user_bit_split & user_chan_b_i;
			ubuf_addr_q <= z_start ? 10'h000 : wptr_q;
			ubuf_data_q <= user_bit_i;
		end
	end
	assign ubuf_we_o = ubuf_we_q;
	assign ubuf_sel_o = ubuf_sel_q;
	assign ubuf_chan_b_o = ubuf_chan_q;
	assign ubuf_addr_o = ubuf_addr_q;
	assign ubuf_data_o = ubuf_data_q;

	// Format follows the live status flag, with no latching at Z
	// R7: professional or consumer format
	always_comb
	begin
		if (user_buffer_mode != MODE_FORMAT)
			user_format_o = 2'(SPRXTX_FMT_NONE);
		else if (professional_flag_i)
			user_format_o = 2'(SPRXTX_FMT_PRO);
		else
			user_format_o = 2'(SPRXTX_FMT_CONSUMER);
	end

	// -----------------------------------------------------------------
	// Transmitter control
	// -----------------------------------------------------------------
	// Sampled per subframe so a subframe never sees a half-made change
	// R9: validity latched at each subframe
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			tx_val_q <= 1'b0;
		else if (ce_i && tx_subframe_i)
			tx_val_q <= tx_ctrl_q[TX_VAL_BIT];
	end
	assign tx_validity_o = tx_val_q;

	// Enable acts at once; the serialiser must close its open frame
	// R12: stream only while enabled
	assign tx_run_o = tx_ctrl_q[TX_EN_BIT];
	// R11: clock source select
	assign transmit_clock_select_o = tx_ctrl_q[TX_CLK_LSB +: 2];
	assign transmit_ratio_o = tx_ctrl_q[TX_RATIO_LSB +: 3];

	// Undefined ratio codes still pass; rate logic checks ratio_valid_o
	// R10: defined ratio codes
	always_comb
	begin
		case (transmit_ratio_o)
			RATIO_1_1, RATIO_1_2, RATIO_1_4, RATIO_2_1, RATIO_4_1:
				ratio_valid_o = 1'b1;
			default:
				ratio_valid_o = 1'b0;
		endcase
	end

endmodule : sprxtx_regs

// ===== logic/sprxtx_pkg.sv
// Constants for the receive user-bit buffer and transmitter control bank.
// Assumes a byte-wide register port; offsets are register indices.
//
// Contract
// R1: Filter set, consumer format, DAT category: user interrupt only on start-bit change.
// R2: Split bit: 0 stores A and B user bits together, 1 separately.
// R3: CS mode 0: flag every complete new 192-frame channel-status block.
// R4: CS mode 1: flag only when first five status bytes differ from previous.
// R5: Buffer mode 00 discards user bits; code 11 reserved, not written.
// R6: Buffer mode 01 fills buffer one then buffer two, alternating.
// R7: Mode 10: professional uses status byte 1 bits 4-7, else consumer format.
// R8: Mode 01 buffer size 384 bits (0) or 768 bits (1), starting at Z.
// R9: Validity field copied into every transmitted subframe validity bit.
// R10: Ratio codes 000 1:1, 001 1:2, 010 1:4, 101 2:1, 110 4:1.
// R11: Clock select 00 internal one, 01 internal two, 10 recovered PLL.
// R12: Transmit stream produced only while transmit enable is 1.
// R13: Reserved bits read zero and ignore writes.
package sprxtx_pkg;

	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [6:0] RX_BUF_CFG_OFF = 7'h0B;
	localparam logic [6:0] TX_CTRL_OFF = 7'h0C;
	localparam logic [6:0] IRQ_STAT_OFF = 7'h11;
	localparam logic [6:0] IRQ_MASK_OFF = 7'h12;
	localparam logic [6:0] RX_STAT_OFF = 7'h13;
	// -----------------------------------------------------------------
	// Fields and masks
	// -----------------------------------------------------------------
	localparam int unsigned RXB_SIZE_BIT = 0;
	localparam int unsigned RXB_MODE_LSB = 1;
	localparam int unsigned RXB_CSMODE_BIT = 3;
	localparam int unsigned RXB_SPLIT_BIT = 4;
	localparam int unsigned RXB_DATF_BIT = 5;
	localparam logic [7:0] RXB_WMASK = 8'h3F;
	localparam int unsigned TX_EN_BIT = 0;
	localparam int unsigned TX_CLK_LSB = 1;
	localparam int unsigned TX_RATIO_LSB = 3;
	localparam int unsigned TX_VAL_BIT = 6;
	localparam logic [7:0] TX_WMASK = 8'h7F;
	localparam logic [7:0] RXB_RESET = 8'h00;
	localparam logic [7:0] TX_RESET = 8'h00;
	localparam logic [1:0] IRQ_W_RESET = 2'h0;
	localparam int unsigned IRQ_USER_BIT = 0;
	localparam int unsigned IRQ_CS_BIT = 1;
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_PINGPONG = 2'h1;
	localparam logic [1:0] MODE_FORMAT = 2'h2;
	localparam logic [1:0] CLK_INT1 = 2'h0;
	localparam logic [1:0] CLK_INT2 = 2'h1;
	localparam logic [1:0] CLK_PLL = 2'h2;
	localparam logic [2:0] RATIO_1_1 = 3'h0;
	localparam logic [2:0] RATIO_1_2 = 3'h1;
	localparam logic [2:0] RATIO_1_4 = 3'h2;
	localparam logic [2:0] RATIO_2_1 = 3'h5;
	localparam logic [2:0] RATIO_4_1 = 3'h6;
	localparam int unsigned BUF_SMALL_BITS = 384;
	localparam int unsigned BUF_LARGE_BITS = 768;
	localparam int unsigned CS_FRAMES = 192;
	localparam int unsigned CS_CMP_BYTES = 5;

	typedef enum logic [1:0] {
		SPRXTX_FMT_NONE,
		SPRXTX_FMT_CONSUMER,
		SPRXTX_FMT_PRO
	} sprxtx_fmt_e;

endpackage : sprxtx_pkg

// ===== test/sprxtx_props.sv
// Port checker for sprxtx_regs.
// Bound from tb; sees only the bank's ports.
`timescale 1ns/10ps
module sprxtx_props
	import sprxtx_pkg::*;
(
	input logic clk_i,
	input logic rstn_i,
	input logic ce_i,
	input logic [6:0] addr_i,
	input logic [7:0] wdata_i,
	input logic wr_i,
	input logic rd_i,
	input logic [7:0] rdata_o,
	input logic user_bit_valid_i,
	input logic user_bit_i,
	input logic tx_subframe_i,
	input logic ubuf_we_o,
	input logic ubuf_data_o,
	input logic tx_run_o,
	input logic tx_validity_o,
	input logic [1:0] transmit_clock_select_o,
	input logic [2:0] transmit_ratio_o,
	input logic ratio_valid_o,
	input logic irq_o
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_tx_wr;
		ce_i && wr_i && addr_i == TX_CTRL_OFF;
	endsequence
	sequence s_frame;
		ce_i && tx_subframe_i && !wr_i;
	endsequence
	chk_tx_enable: assert property (s_tx_wr |=>
		tx_run_o == $past(wdata_i[0])) else $error("tx enable");
	chk_clock_sel: assert property (s_tx_wr |=>
		transmit_clock_select_o == $past(wdata_i[2:1])) else $error("clk");
	chk_ratio_set: assert property (s_tx_wr |=>
		transmit_ratio_o == $past(wdata_i[5:3])) else $error("ratio");
	chk_ratio_code: assert property (ratio_valid_o ==
		(transmit_ratio_o inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}))
		else $error("ratio code");
	// Helper: validity last written over the bus, the reference
	logic last_val_q;
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			last_val_q <= 1'b0;
		else if (ce_i && wr_i && addr_i == TX_CTRL_OFF)
			last_val_q <= wdata_i[TX_VAL_BIT];
	end
	chk_valid_copy: assert property (s_frame |=>
		tx_validity_o == $past(last_val_q)) else $error("validity");
	chk_tx_resv: assert property (ce_i && rd_i && addr_i == TX_CTRL_OFF |=>
		!rdata_o[7]) else $error("reserved");
	chk_irq_mask: assert property (ce_i && wr_i && addr_i == IRQ_MASK_OFF &&
		wdata_i[1:0] == 2'h0 |=> !irq_o) else $error("mask");
	chk_ubuf_copy: assert property (ubuf_we_o && $past(ce_i) |->
		$past(user_bit_valid_i) && ubuf_data_o == $past(user_bit_i))
		else $error("ubuf");
endmodule : sprxtx_props

// ===== test/sprxtx_far.sv
// Far-side audio equipment: receiver events and subframe timing.
// Used through its tasks; every change follows a clk_i rising edge.
`timescale 1ns/10ps
module sprxtx_far
(
	input logic clk_i,
	output logic user_bit_valid_i,
	output logic user_bit_i,
	output logic user_chan_b_i,
	output logic preamble_z_i,
	output logic user_irq_evt_i,
	output logic dat_category_i,
	output logic start_id_bit_i,
	output logic professional_flag_i,
	output logic cs_block_done_i,
	output logic cs_head_changed_i,
	output logic tx_subframe_i
);
	// ----------
	// Stimulus
	// ----------
	initial
	begin
		{user_bit_valid_i, user_bit_i, user_chan_b_i, preamble_z_i} = 4'h0;
		{user_irq_evt_i, dat_category_i, start_id_bit_i} = 3'h0;
		{professional_flag_i, cs_block_done_i, cs_head_changed_i} = 3'h0;
		tx_subframe_i = 1'b0;
	end
	task lvl(input logic professional_flag, input logic dat);
		@(posedge clk_i);
		{professional_flag_i, dat_category_i} <= {professional_flag, dat};
	endtask : lvl
	task frame(input logic b, input logic z);
		@(posedge clk_i);
		{user_bit_valid_i, tx_subframe_i, user_bit_i} <= {2'h3, b};
		{preamble_z_i, user_chan_b_i} <= {z, ~user_chan_b_i};
		@(posedge clk_i);
		{user_bit_valid_i, tx_subframe_i, preamble_z_i} <= 3'h0;
		// Released data line shows the inverse, not a stale value
		user_bit_i <= ~b;
	endtask : frame
	task csb(input logic chg);
		@(posedge clk_i);
		{cs_block_done_i, cs_head_changed_i} <= {1'b1, chg};
		@(posedge clk_i);
		{cs_block_done_i, cs_head_changed_i} <= {1'b0, ~chg};
	endtask : csb
	task uevt(input logic sid);
		@(posedge clk_i);
		{user_irq_evt_i, start_id_bit_i} <= {1'b1, sid};
		@(posedge clk_i);
		{user_irq_evt_i, start_id_bit_i} <= {1'b0, ~sid};
	endtask : uevt
endmodule : sprxtx_far

// ===== test/tb.sv
// Bench top for sprxtx_regs with far-side model and bound checker.
// Assumes the package and design are compiled first.
`timescale 1ns/10ps
module tb;
	import sprxtx_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i;
	logic ce_i;
	logic [6:0] addr_i;
	logic [7:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [7:0] rdata_o;
	logic user_bit_valid_i, user_bit_i, user_chan_b_i, preamble_z_i;
	logic user_irq_evt_i, dat_category_i, start_id_bit_i;
	logic professional_flag_i, cs_block_done_i, cs_head_changed_i;
	logic ubuf_we_o, ubuf_sel_o, ubuf_chan_b_o, ubuf_data_o, irq_o;
	logic [9:0] ubuf_addr_o;
	logic [1:0] user_format_o, transmit_clock_select_o;
	logic tx_subframe_i, tx_run_o, tx_validity_o, ratio_valid_o;
	logic [2:0] transmit_ratio_o;
	int fails = 0;
	int cmp_count = 0;
	// Rows: write value, read-back, ratio accepted
	logic [7:0] rows [9][3] = '{'{8'h80, 8'h00, 8'h01},
		'{8'h03, 8'h03, 8'h01}, '{8'h0D, 8'h0D, 8'h01},
		'{8'h14, 8'h14, 8'h01}, '{8'h18, 8'h18, 8'h00},
		'{8'h20, 8'h20, 8'h00}, '{8'h29, 8'h29, 8'h01},
		'{8'h31, 8'h31, 8'h01}, '{8'hFF, 8'h7F, 8'h00}};
	always #4 clk_i = ~clk_i;
	sprxtx_regs sprxtx_regs_i (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.user_bit_valid_i(user_bit_valid_i), .user_bit_i(user_bit_i),
		.user_chan_b_i(user_chan_b_i), .preamble_z_i(preamble_z_i),
		.user_irq_evt_i(user_irq_evt_i), .dat_category_i(dat_category_i),
		.start_id_bit_i(start_id_bit_i),
		.professional_flag_i(professional_flag_i),
		.cs_block_done_i(cs_block_done_i),
		.cs_head_changed_i(cs_head_changed_i),
		.ubuf_we_o(ubuf_we_o), .ubuf_sel_o(ubuf_sel_o),
		.ubuf_chan_b_o(ubuf_chan_b_o), .ubuf_addr_o(ubuf_addr_o),
		.ubuf_data_o(ubuf_data_o), .user_format_o(user_format_o),
		.tx_subframe_i(tx_subframe_i), .tx_run_o(tx_run_o),
		.tx_validity_o(tx_validity_o),
		.transmit_clock_select_o(transmit_clock_select_o),
		.transmit_ratio_o(transmit_ratio_o),
		.ratio_valid_o(ratio_valid_o), .irq_o(irq_o)
	);
	sprxtx_far sprxtx_far_i (
		.clk_i(clk_i), .user_bit_valid_i(user_bit_valid_i),
		.user_bit_i(user_bit_i), .user_chan_b_i(user_chan_b_i),
		.preamble_z_i(preamble_z_i), .user_irq_evt_i(user_irq_evt_i),
		.dat_category_i(dat_category_i), .start_id_bit_i(start_id_bit_i),
		.professional_flag_i(professional_flag_i),
		.cs_block_done_i(cs_block_done_i),
		.cs_head_changed_i(cs_head_changed_i),
		.tx_subframe_i(tx_subframe_i)
	);
	// ----------
	// Tasks
	// ----------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{wr_i, addr_i, wdata_i} <= {1'b1, a, d};
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rdc(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_i);
		{rd_i, addr_i} <= {1'b1, a};
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rdc
	task close_out;
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fails++;
		close_out;
	end
	// ----------
	// Sequence
	// ----------
	initial
	begin
		rstn_i <= 1'b0;
		ce_i <= 1'b1;
		{wr_i, rd_i} <= 2'h0;
		{addr_i, wdata_i} <= 15'h0000;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		rdc(RX_BUF_CFG_OFF, RXB_RESET);
		rdc(TX_CTRL_OFF, TX_RESET);
		foreach (rows[i])
		begin
			wr(TX_CTRL_OFF, rows[i][0]);
			rdc(TX_CTRL_OFF, rows[i][1]);
			chk({2'h0, transmit_ratio_o, transmit_clock_select_o, tx_run_o},
				rows[i][1] & 8'h3F);
			chk({7'h0, ratio_valid_o}, rows[i][2]);
		end
		wr(RX_BUF_CFG_OFF, 8'hFF);
		rdc(RX_BUF_CFG_OFF, RXB_WMASK);
		wr(7'h7F, 8'hAA);
		rdc(7'h7F, 8'h00);
		for (int v = 0; v < 3; v++)
		begin
			wr(TX_CTRL_OFF, {1'b0, v[0], 6'h01});
			sprxtx_far_i.frame(1'b0, 1'b0);
			#1 chk({7'h0, tx_validity_o}, {7'h0, v[0]});
		end
		wr(RX_BUF_CFG_OFF, 8'h04);
		sprxtx_far_i.lvl(1'b1, 1'b0);
		#1 chk({6'h0, user_format_o}, 8'h02);
		sprxtx_far_i.lvl(1'b0, 1'b0);
		#1 chk({6'h0, user_format_o}, 8'h01);
		wr(RX_BUF_CFG_OFF, 8'h00);
		sprxtx_far_i.frame(1'b1, 1'b1);
		#1 chk({ubuf_we_o, 5'h0, user_format_o}, 8'h00);
		wr(RX_BUF_CFG_OFF, 8'h02);
		sprxtx_far_i.frame(1'b1, 1'b1);
		#1 chk({ubuf_we_o, ubuf_sel_o, ubuf_data_o, ubuf_addr_o[4:0]}, 8'hA0);
		for (int k = 1; k <= BUF_SMALL_BITS; k++)
			sprxtx_far_i.frame(k[0], 1'b0);
		#1 chk({ubuf_we_o, ubuf_sel_o, ubuf_addr_o[5:0]}, 8'hC0);
		rdc(RX_STAT_OFF, 8'h03);
		// Split on, then off: the B flag follows the channel only when split
		for (int s = 0; s < 4; s++)
		begin
			wr(RX_BUF_CFG_OFF, s[1] ? 8'h02 : 8'h12);
			sprxtx_far_i.frame(1'b0, 1'b0);
			#1 chk({6'h0, ubuf_we_o, ubuf_chan_b_o},
				{7'h1, ~s[1] & user_chan_b_i});
		end
		wr(IRQ_MASK_OFF, 8'h03);
		rdc(IRQ_MASK_OFF, 8'h03);
		wr(RX_BUF_CFG_OFF, 8'h00);
		sprxtx_far_i.csb(1'b0);
		#1 chk({7'h0, irq_o}, 8'h01);
		rdc(IRQ_STAT_OFF, 8'h02);
		chk({7'h0, irq_o}, 8'h00);
		wr(RX_BUF_CFG_OFF, 8'h08);
		sprxtx_far_i.csb(1'b0);
		#1 chk({7'h0, irq_o}, 8'h00);
		wr(IRQ_MASK_OFF, 8'h00);
		sprxtx_far_i.csb(1'b1);
		#1 chk({7'h0, irq_o}, 8'h00);
		wr(IRQ_MASK_OFF, 8'h03);
		rdc(IRQ_STAT_OFF, 8'h02);
		wr(RX_BUF_CFG_OFF, 8'h24);
		sprxtx_far_i.lvl(1'b0, 1'b1);
		sprxtx_far_i.uevt(1'b0);
		sprxtx_far_i.uevt(1'b1);
		rdc(IRQ_STAT_OFF, 8'h01);
		sprxtx_far_i.uevt(1'b1);
		#1 chk({7'h0, irq_o}, 8'h00);
		wr(RX_BUF_CFG_OFF, 8'h04);
		sprxtx_far_i.uevt(1'b1);
		#1 chk({7'h0, irq_o}, 8'h01);
		// Clock enable low: a write must not land
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(TX_CTRL_OFF, 8'h7E);
		ce_i <= 1'b1;
		rdc(TX_CTRL_OFF, 8'h01);
		// Mid-run reset clears the bank and the pending status
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1 chk({7'h0, irq_o}, 8'h00);
		rdc(TX_CTRL_OFF, TX_RESET);
		rdc(RX_BUF_CFG_OFF, RXB_RESET);
		rdc(IRQ_STAT_OFF, 8'h00);
		close_out;
	end
endmodule : tb
bind sprxtx_regs sprxtx_props sprxtx_props_i (
	.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.user_bit_valid_i(user_bit_valid_i), .user_bit_i(user_bit_i),
	.tx_subframe_i(tx_subframe_i), .ubuf_we_o(ubuf_we_o),
	.ubuf_data_o(ubuf_data_o), .tx_run_o(tx_run_o),
	.tx_validity_o(tx_validity_o),
	.transmit_clock_select_o(transmit_clock_select_o),
	.transmit_ratio_o(transmit_ratio_o),
	.ratio_valid_o(ratio_valid_o), .irq_o(irq_o)
);
